// ==== logic/aq_pkg.sv ====
// shared constants and carrier types for the action qualifier
`default_nettype none

package aq_pkg;

    // ****************************************
    // register map (byte offsets)
    // ****************************************
    localparam logic [3:0] off_b_actions = 4'h0;
    localparam logic [3:0] off_single_force = 4'h4;
    localparam logic [3:0] off_hold_force = 4'h8;

    // ****************************************
    // field positions
    // ****************************************
    localparam int pos_cmp_b_down = 10;
    localparam int pos_cmp_b_up = 8;
    localparam int pos_cmp_a_down = 6;
    localparam int pos_cmp_a_up = 4;
    localparam int pos_period = 2;
    localparam int pos_zero = 0;
    localparam int pos_reload_sel = 6;
    localparam int pos_trig_b = 5;
    localparam int pos_single_act_b = 3;
    localparam int pos_trig_a = 2;
    localparam int pos_single_act_a = 0;
    localparam int pos_hold_b = 2;
    localparam int pos_hold_a = 0;

    // ****************************************
    // widths and reset values
    // ****************************************
    localparam int b_actions_bits = 12;
    localparam int single_force_bits = 8;
    localparam int hold_force_bits = 4;
    localparam logic [11:0] b_actions_rst = 12'h000;
    localparam logic [7:0] single_force_rst = 8'h00;
    localparam logic [3:0] hold_force_rst = 4'h0;

    // ****************************************
    // encodings
    // ****************************************
    localparam logic [1:0] act_none = 2'h0;
    localparam logic [1:0] act_low = 2'h1;
    localparam logic [1:0] act_high = 2'h2;
    localparam logic [1:0] act_invert = 2'h3;
    localparam logic [1:0] reload_zero = 2'h0;
    localparam logic [1:0] reload_period = 2'h1;
    localparam logic [1:0] reload_either = 2'h2;
    localparam logic [1:0] reload_direct = 2'h3;
    localparam logic dir_down = 1'b0;
    localparam logic dir_up = 1'b1;

    // events from the time-base and compare logic, same clock
    typedef struct packed {
        logic up_down_mode;
        logic count_direction;
        logic zero_match;
        logic period_match;
        logic cmp_a_match;
        logic cmp_b_match;
    } tb_events_s;

    typedef enum logic [1:0] {
        bus_idle = 2'b01,
        bus_ack = 2'b10
    } bus_state_e;

endpackage

`default_nettype wire

// ==== logic/pwm_action_qualifier_sw_force.sv ====
// action qualifier for output b with one-time and continuous software forces
//
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`default_nettype none

module pwm_action_qualifier_sw_force (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // time-base events
    input wire aq_pkg::tb_events_s tb_events,
    // qualified outputs to the dead-band stage
    output logic pwm_output_first,
    output logic pwm_output_second
);

    // ****************************************
    // registers and decoded state
    // ****************************************
    logic [11:0] output_b_event_actions;
    logic [1:0] force_reload_select;
    logic [1:0] single_force_action_out_b;
    logic [1:0] single_force_action_out_a;
    logic [3:0] hold_force_shadow;
    logic [3:0] continuous_force_control;
    logic single_force_trigger_out_b;
    logic single_force_trigger_out_a;
    logic level_b;
    logic level_a;
    aq_pkg::bus_state_e bus_state;
    aq_pkg::bus_state_e next_bus_state;
    logic accept;
    logic wr_en;
    logic [15:0] wmask;
    logic [15:0] wdata;
    logic [31:0] next_readdata;
    logic eff_dir;
    logic [1:0] b_event_act;
    logic [1:0] next_b_act;
    logic [1:0] next_a_act;
    logic shadow_load;
    logic [1:0] act_cmp_b_down;
    logic [1:0] act_cmp_b_up;
    logic [1:0] act_cmp_a_down;
    logic [1:0] act_cmp_a_up;
    logic [1:0] act_period;
    logic [1:0] act_zero;

    // ****************************************
    // action helper
    // ****************************************
    function automatic logic apply_act(input logic [1:0] act, input logic cur);
        logic res;
        res = cur;
        unique case (act)
            aq_pkg::act_none: res = cur;
            aq_pkg::act_low: res = 1'b0;
            aq_pkg::act_high: res = 1'b1;
            aq_pkg::act_invert: res = ~cur;
        endcase
        return res;
    endfunction

    function automatic logic [1:0] field(input logic [11:0] r, input int pos);
        logic [1:0] f;
        f = r[pos +: 2];
        return f;
    endfunction

    // ****************************************
    // bus handshake
    // ****************************************
    // one wait cycle per access: the answer is registered, so readdata
    // and waitrequest both come straight from flip-flops
    always_comb begin
        next_bus_state = bus_state;
        unique case (bus_state)
            aq_pkg::bus_idle: begin
                if (read || write) begin
                    next_bus_state = aq_pkg::bus_ack;
                end
            end
            aq_pkg::bus_ack: begin
                next_bus_state = aq_pkg::bus_idle;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bus_state <= aq_pkg::bus_idle;
        end else begin
            bus_state <= next_bus_state;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= (next_bus_state != aq_pkg::bus_ack);
        end
    end

    assign accept = (bus_state == aq_pkg::bus_ack);
    assign wr_en = accept && write;

    always_comb begin
        wmask = {{8{byteenable[1]}}, {8{byteenable[0]}}};
        wdata = writedata[15:0];
    end

    // ****************************************
    // read path
    // ****************************************
    // trigger bits and reserved bits are never stored, so they read zero
    always_comb begin
        next_readdata = 32'h0;
        unique case (address)
            aq_pkg::off_b_actions: begin
                next_readdata[11:0] = output_b_event_actions;
            end
            aq_pkg::off_single_force: begin
                next_readdata[aq_pkg::pos_reload_sel +: 2] = force_reload_select;
                next_readdata[aq_pkg::pos_single_act_b +: 2] = single_force_action_out_b;
                next_readdata[aq_pkg::pos_single_act_a +: 2] = single_force_action_out_a;
                next_readdata[aq_pkg::pos_trig_b] = 1'b0;
                next_readdata[aq_pkg::pos_trig_a] = 1'b0;
            end
            aq_pkg::off_hold_force: begin
                // software sees what it wrote last: shadow unless direct
                if (force_reload_select == aq_pkg::reload_direct) begin
                    next_readdata[3:0] = continuous_force_control;
                end else begin
                    next_readdata[3:0] = hold_force_shadow;
                end
            end
            default: begin
                next_readdata = 32'h0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            readdata <= 32'h0;
        end else if (bus_state == aq_pkg::bus_idle && read) begin
            readdata <= next_readdata;
        end
    end

    // ****************************************
    // event action register
    // ****************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            output_b_event_actions <= aq_pkg::b_actions_rst;
        end else if (wr_en && address == aq_pkg::off_b_actions) begin
            output_b_event_actions <= (output_b_event_actions & ~wmask[11:0])
                | (wdata[11:0] & wmask[11:0]);
        end
    end

    // ****************************************
    // single force register
    // ****************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            force_reload_select <= aq_pkg::single_force_rst[7:6];
            single_force_action_out_b <= aq_pkg::single_force_rst[4:3];
            single_force_action_out_a <= aq_pkg::single_force_rst[1:0];
        end else if (wr_en && address == aq_pkg::off_single_force && byteenable[0]) begin
            force_reload_select <= wdata[aq_pkg::pos_reload_sel +: 2];
            single_force_action_out_b <= wdata[aq_pkg::pos_single_act_b +: 2];
            single_force_action_out_a <= wdata[aq_pkg::pos_single_act_a +: 2];
        end
    end

    // trigger pulses one cycle after the write completes, then clears itself
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            single_force_trigger_out_b <= 1'b0;
            single_force_trigger_out_a <= 1'b0;
        end else begin
            single_force_trigger_out_b <= wr_en && address == aq_pkg::off_single_force
                && byteenable[0] && wdata[aq_pkg::pos_trig_b];
            single_force_trigger_out_a <= wr_en && address == aq_pkg::off_single_force
                && byteenable[0] && wdata[aq_pkg::pos_trig_a];
        end
    end

    // ****************************************
    // continuous force, shadow and active
    // ****************************************
    always_comb begin
        unique case (force_reload_select)
            aq_pkg::reload_zero: shadow_load = tb_events.zero_match;
            aq_pkg::reload_period: shadow_load = tb_events.period_match;
            aq_pkg::reload_either: begin
                shadow_load = tb_events.zero_match || tb_events.period_match;
            end
            aq_pkg::reload_direct: shadow_load = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hold_force_shadow <= aq_pkg::hold_force_rst;
        end else if (wr_en && address == aq_pkg::off_hold_force && byteenable[0]
                && force_reload_select != aq_pkg::reload_direct) begin
            hold_force_shadow <= wdata[3:0];
        end
    end

    // a write in direct mode lands in the active copy; a shadow load that
    // falls in the same cycle cannot happen since direct mode has none
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            continuous_force_control <= aq_pkg::hold_force_rst;
        end else if (wr_en && address == aq_pkg::off_hold_force && byteenable[0]
                && force_reload_select == aq_pkg::reload_direct) begin
            continuous_force_control <= wdata[3:0];
        end else if (shadow_load) begin
            continuous_force_control <= hold_force_shadow;
        end
    end

    // ****************************************
    // direction qualification
    // ****************************************
    always_comb begin
        eff_dir = tb_events.count_direction;
        if (tb_events.up_down_mode && tb_events.period_match) begin
            eff_dir = aq_pkg::dir_down;
        end else if (tb_events.up_down_mode && tb_events.zero_match) begin
            eff_dir = aq_pkg::dir_up;
        end
    end

    // ****************************************
    // event selection for output b
    // ****************************************
    // a field of 00 disables its event, so it never masks a lower-ranked one;
    // among enabled events zero and period win over compares, compare b over
    // compare a; this keeps the up-down direction override visible on compares
    always_comb begin
        act_cmp_b_down = field(output_b_event_actions, aq_pkg::pos_cmp_b_down);
        act_cmp_b_up = field(output_b_event_actions, aq_pkg::pos_cmp_b_up);
        act_cmp_a_down = field(output_b_event_actions, aq_pkg::pos_cmp_a_down);
        act_cmp_a_up = field(output_b_event_actions, aq_pkg::pos_cmp_a_up);
        act_period = field(output_b_event_actions, aq_pkg::pos_period);
        act_zero = field(output_b_event_actions, aq_pkg::pos_zero);
    end

    always_comb begin
        b_event_act = aq_pkg::act_none;
        if (tb_events.cmp_a_match && eff_dir == aq_pkg::dir_up
                && act_cmp_a_up != aq_pkg::act_none) begin
            b_event_act = act_cmp_a_up;
        end
        if (tb_events.cmp_a_match && eff_dir == aq_pkg::dir_down
                && act_cmp_a_down != aq_pkg::act_none) begin
            b_event_act = act_cmp_a_down;
        end
        if (tb_events.cmp_b_match && eff_dir == aq_pkg::dir_up
                && act_cmp_b_up != aq_pkg::act_none) begin
            b_event_act = act_cmp_b_up;
        end
        if (tb_events.cmp_b_match && eff_dir == aq_pkg::dir_down
                && act_cmp_b_down != aq_pkg::act_none) begin
            b_event_act = act_cmp_b_down;
        end
        if (tb_events.period_match
                && act_period != aq_pkg::act_none) begin
            b_event_act = act_period;
        end
        if (tb_events.zero_match
                && act_zero != aq_pkg::act_none) begin
            b_event_act = act_zero;
        end
    end

    // software single force outranks any counter event in its cycle
    always_comb begin
        next_b_act = b_event_act;
        if (single_force_trigger_out_b) begin
            next_b_act = single_force_action_out_b;
        end
        next_a_act = aq_pkg::act_none;
        if (single_force_trigger_out_a) begin
            next_a_act = single_force_action_out_a;
        end
    end

    // ****************************************
    // qualified levels
    // ****************************************
    // the forced level is just stored state, so any later event with a non-00 action on b rewrites it
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            level_b <= 1'b0;
        end else begin
            level_b <= apply_act(next_b_act, level_b);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            level_a <= 1'b0;
        end else begin
            level_a <= apply_act(next_a_act, level_a);
        end
    end

    // ****************************************
    // outputs with continuous force
    // ****************************************
    // the hold override reads the active copy, so it shows one edge after
    // that copy changes; the underlying level keeps running meanwhile
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pwm_output_second <= 1'b0;
        end else begin
            unique case (continuous_force_control[aq_pkg::pos_hold_b +: 2])
                aq_pkg::act_low: pwm_output_second <= 1'b0;
                aq_pkg::act_high: pwm_output_second <= 1'b1;
                aq_pkg::act_none, aq_pkg::act_invert: begin
                    pwm_output_second <= apply_act(next_b_act, level_b);
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pwm_output_first <= 1'b0;
        end else begin
            unique case (continuous_force_control[aq_pkg::pos_hold_a +: 2])
                aq_pkg::act_low: pwm_output_first <= 1'b0;
                aq_pkg::act_high: pwm_output_first <= 1'b1;
                aq_pkg::act_none, aq_pkg::act_invert: begin
                    pwm_output_first <= apply_act(next_a_act, level_a);
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ==== sim/aq_event_source.sv ====
// time-base event source model feeding the qualifier
`default_nettype none

module aq_event_source (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // command from the bench: kind bits are zero, period, cmp a, cmp b
    input wire logic fire,
    input wire logic [3:0] kind,
    input wire logic count_up,
    input wire logic up_down,
    // events toward the qualifier
    output var aq_pkg::tb_events_s tb_events
);
    timeunit 1ns;
    timeprecision 1ps;
    // matches are single-cycle pulses, mode and direction are levels
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tb_events <= '0;
        end else begin
            tb_events.up_down_mode <= up_down;
            tb_events.count_direction <= count_up;
            tb_events.zero_match <= fire & kind[3];
            tb_events.period_match <= fire & kind[2];
            tb_events.cmp_a_match <= fire & kind[1];
            tb_events.cmp_b_match <= fire & kind[0];
        end
    end
endmodule

`default_nettype wire

// ==== sim/aq_props.sv ====
// port-level assertions for the action qualifier
`default_nettype none

module aq_props (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register bus
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // events and outputs
    input wire aq_pkg::tb_events_s tb_events,
    input wire logic pwm_output_first,
    input wire logic pwm_output_second
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ****************************************
    // helpers
    // ****************************************
    logic ack;
    logic ev_any;
    logic ev_load;
    assign ack = !waitrequest;
    assign ev_load = tb_events.zero_match | tb_events.period_match;
    assign ev_any = ev_load | tb_events.cmp_a_match | tb_events.cmp_b_match;

    // ****************************************
    // assertions
    // ****************************************
    chk_ack_after_take: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered one cycle after take");
    chk_ack_one_cycle: assert property (ack |=> waitrequest)
        else $error("waitrequest low longer than one cycle");
    chk_idle_wait: assert property (!(read || write) |=> waitrequest)
        else $error("answer without a request");
    chk_upper_zero: assert property (ack && read |-> readdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    chk_unmapped_zero: assert property (ack && read && !(address inside {4'h0, 4'h4, 4'h8})
        |-> readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_trig_reads_zero: assert property (
        ack && read && address == aq_pkg::off_single_force
        |-> readdata[15:8] == 8'h00 && !readdata[5] && !readdata[2])
        else $error("trigger or reserved bit read as one");
    chk_act_rsvd_zero: assert property (
        ack && read && address == aq_pkg::off_b_actions |-> readdata[15:12] == 4'h0)
        else $error("action register reserved bits set");
    chk_hold_rsvd_zero: assert property (
        ack && read && address == aq_pkg::off_hold_force |-> readdata[15:4] == 12'h000)
        else $error("hold force reserved bits set");
    // b moves one cycle after an event, two after a shadow load or an acked write
    chk_b_cause: assert property ($changed(pwm_output_second)
        |-> $past(ev_any) || $past(ev_load, 2) || $past(ack && write, 2))
        else $error("output b changed without cause");
    // a has no event actions: only a shadow load or an acked write moves it
    chk_a_cause: assert property ($changed(pwm_output_first)
        |-> $past(ev_load, 2) || $past(ack && write, 2))
        else $error("output a changed without cause");
endmodule

bind pwm_action_qualifier_sw_force aq_props u_props (
    .clk_sys(clk_sys),
    .rst(rst),
    .address(address),
    .read(read),
    .write(write),
    .byteenable(byteenable),
    .writedata(writedata),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .tb_events(tb_events),
    .pwm_output_first(pwm_output_first),
    .pwm_output_second(pwm_output_second)
);

`default_nettype wire

// ==== sim/tb_pwm_action_qualifier_sw_force.sv ====
// self-checking bench for the action qualifier
`default_nettype none

module tb_pwm_action_qualifier_sw_force;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // signals
    // ****************************************
    logic clk_sys, rst, read, write, waitrequest, fire, count_up, up_down, eb;
    logic [3:0] address, byteenable, kind;
    logic [31:0] writedata, readdata, rd;
    aq_pkg::tb_events_s tb_events;
    int fails, check_count;
    int pos[6] = '{10, 8, 6, 4, 2, 0};
    logic [3:0] ek[6] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h4, 4'h8};
    logic [3:0] dk[6] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h8, 4'h4};
    logic dr[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic [15:0] cd[5] = '{16'h0002, 16'h0003, 16'h0003, 16'h0001, 16'h0000};
    logic ex[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    logic [3:0] wk[3] = '{4'h4, 4'h8, 4'h1};
    logic [3:0] rk[3] = '{4'h8, 4'h4, 4'h4};
    logic [3:0] rl[3] = '{4'h8, 4'h4, 4'h8};

    aq_event_source u_src (.clk_sys(clk_sys), .rst(rst), .fire(fire), .kind(kind),
        .count_up(count_up), .up_down(up_down), .tb_events(tb_events));

    pwm_action_qualifier_sw_force dut (.clk_sys(clk_sys), .rst(rst), .address(address),
        .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .tb_events(tb_events),
        .pwm_output_first(), .pwm_output_second());

    // ****************************************
    // tasks
    // ****************************************
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // a stuck waitrequest ends the run instead of hanging it
    task automatic access(input logic wr, input logic [3:0] adr, input logic [15:0] d,
        input logic [3:0] be);
        int n;
        @(posedge clk_sys);
        read <= !wr;
        write <= wr;
        address <= adr;
        writedata <= {16'h0000, d};
        byteenable <= be;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (waitrequest === 1'b0) break;
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n == 50) begin
            fails++;
            report_and_stop();
        end
    endtask

    task automatic wr(input logic [3:0] adr, input logic [15:0] d);
        access(1'b1, adr, d, 4'h3);
    endtask

    task automatic rchk(input logic [3:0] adr, input logic [31:0] exp);
        access(1'b0, adr, 16'h0000, 4'h3);
        check(rd, exp);
    endtask

    // outputs only move on events or writes, so a few quiet cycles settle them
    task automatic settle();
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    task automatic pulse(input logic [3:0] k, input logic up);
        @(posedge clk_sys);
        fire <= 1'b1;
        kind <= k;
        count_up <= up;
        @(posedge clk_sys);
        fire <= 1'b0;
        settle();
    endtask

    task automatic outs(input logic [1:0] exp);
        check({dut.pwm_output_first, dut.pwm_output_second}, {30'h0, exp});
    endtask

    // ****************************************
    // clock and sequence
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    initial begin
        rst = 1'b1;
        {read, write, fire, count_up, up_down} = 5'h00;
        {address, byteenable, kind} = 12'h000;
        writedata = 32'h0000_0000;
        fails = 0;
        check_count = 0;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        rchk(aq_pkg::off_b_actions, 32'h0000_0000);
        rchk(aq_pkg::off_single_force, 32'h0000_0000);
        rchk(aq_pkg::off_hold_force, 32'h0000_0000);
        rchk(4'hc, 32'h0000_0000);
        wr(aq_pkg::off_b_actions, 16'hffff);
        rchk(aq_pkg::off_b_actions, 32'h0000_0fff);
        wr(aq_pkg::off_single_force, 16'hffff);
        settle();
        outs(2'b11);
        rchk(aq_pkg::off_single_force, 32'h0000_00db);
        access(1'b1, aq_pkg::off_hold_force, 16'hfff5, 4'h2);
        rchk(aq_pkg::off_hold_force, 32'h0000_0000);
        wr(aq_pkg::off_hold_force, 16'hffff);
        rchk(aq_pkg::off_hold_force, 32'h0000_000f);
        settle();
        outs(2'b11);
        wr(aq_pkg::off_hold_force, 16'h0005);
        settle();
        outs(2'b00);
        wr(aq_pkg::off_hold_force, 16'h0000);
        settle();
        outs(2'b11);
        wr(aq_pkg::off_single_force, 16'h0029);
        settle();
        outs(2'b10);
        wr(aq_pkg::off_single_force, 16'h0005);
        settle();
        outs(2'b00);
        for (int i = 0; i < 6; i++) begin
            wr(aq_pkg::off_single_force, 16'h0028);
            eb = 1'b0;
            for (int c = 0; c < 5; c++) begin
                wr(aq_pkg::off_b_actions, cd[c] << pos[i]);
                pulse(dk[i], !dr[i]);
                check(dut.pwm_output_second, eb);
                eb = ex[c];
                pulse(ek[i], dr[i]);
                check(dut.pwm_output_second, eb);
            end
        end
        // shadowed hold force only lands on its chosen load event
        wr(aq_pkg::off_b_actions, 16'h0000);
        for (int s = 0; s < 3; s++) begin
            wr(aq_pkg::off_single_force, 16'(s) << 6);
            wr(aq_pkg::off_hold_force, 16'h000a);
            pulse(wk[s], 1'b0);
            outs(2'b00);
            pulse(rk[s], 1'b0);
            outs(2'b11);
            wr(aq_pkg::off_hold_force, 16'h0000);
            pulse(rl[s], 1'b0);
            outs(2'b00);
        end
        // up-down mode: period reads as down and zero as up, compares included
        @(posedge clk_sys);
        up_down <= 1'b1;
        wr(aq_pkg::off_b_actions, 16'h0800);
        pulse(4'h5, 1'b1);
        check(dut.pwm_output_second, 1'b1);
        wr(aq_pkg::off_b_actions, 16'h0010);
        pulse(4'ha, 1'b0);
        check(dut.pwm_output_second, 1'b0);
        report_and_stop();
    end
endmodule

`default_nettype wire
